// ==== inc/charger_status_regs.svh ====
// register offsets, field positions, reset values and counts of the charger status word
`ifndef CHARGER_STATUS_REGS_SVH
`define CHARGER_STATUS_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFF_OPERATING_STATE     8'h21
`define OFF_FAULT_FLAGS         8'h20

// ****************************************
// operating state fields
// ****************************************
`define BIT_VOLTAGE_REG_ACTIVE  4
`define BIT_CURRENT_REG_ACTIVE  3
`define BIT_FAST_CHARGE         2
`define BIT_PRECHARGE           1
`define BIT_REVERSE_POWER       0

// ****************************************
// fault flag fields
// ****************************************
`define BIT_INPUT_OV            7
`define BIT_BATTERY_OC          6
`define BIT_INPUT_OC            5
`define BIT_SYSTEM_OV           4
`define BIT_SYSTEM_UV           3
`define BIT_FORCED_SHUTDOWN     2
`define BIT_REVERSE_OUT_OV      1
`define BIT_REVERSE_OUT_UV      0

// ****************************************
// reset values and counts
// ****************************************
`define RST_OPERATING_STATE     8'h00
`define RST_FAULT_FLAGS         8'h00
`define RST_READ_DATA           8'h00
`define RESTART_FAIL_LIMIT      7
`define READ_CLEAR_COUNT        6

`endif

// ==== inc/charger_status_pkg.sv ====
// types shared by the charger status word and its helpers
package charger_status_pkg;

  // ****************************************
  // host register access, one request a cycle
  // ****************************************
  typedef struct packed {
    logic       rd_en;
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // ****************************************
  // live operating conditions from the power stage
  // ****************************************
  typedef struct packed {
    logic input_voltage_regulation;
    logic otg_voltage_regulation;
    logic input_current_regulation;
    logic fast_charge_active;
    logic precharge_active;
    logic reverse_power_active;
  } live_status_t;

  // ****************************************
  // fault detector outputs
  // ****************************************
  typedef struct packed {
    logic input_overvoltage;
    logic battery_overcurrent;
    logic battery_overvoltage;
    logic input_overcurrent;
    logic system_overvoltage;
    logic system_below_uv;
    logic restart_failed;
    logic reverse_output_overvoltage;
    logic reverse_output_undervoltage;
  } fault_events_t;

  // ****************************************
  // mode and control inputs
  // ****************************************
  typedef struct packed {
    logic pass_through_mode;
    logic battery_overcurrent_enable;
    logic forced_shutdown_command;
    logic adapter_present;
  } mode_cfg_t;

  typedef enum logic [1:0] {
    UV_IDLE,
    UV_RETRY,
    UV_LATCHED
  } uv_state_t;

  typedef struct packed {
    logic [7:0] op_state;
    logic       sys_ov;
    logic       sys_uv;
    logic [7:0] rdata;
    logic       adapter_prev;
    logic       forced_prev;
    logic       conv_en;
  } main_state_t;

endpackage

// ==== logic/read_clear_flags.sv ====
// bank of sticky fault flags that a host read clears
`include "charger_status_regs.svh"
module read_clear_flags
  import charger_status_pkg::*;
#(
  parameter int WIDTH = `READ_CLEAR_COUNT
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic             read_clear,
  output logic      [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flag;
  } bank_state_t;

  bank_state_t state_d;
  bank_state_t state_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("read_clear_flags: WIDTH must be at least 1");
  end

  // set beats the clear so an event during the read is kept
  always_comb begin
    state_d = state_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (set[i]) state_d.flag[i] = 1'b1;
      else if (read_clear) state_d.flag[i] = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) state_q <= '0;
    else state_q <= state_d;
  end

  assign flags = state_q.flag;

endmodule

// ==== logic/uv_restart_monitor.sv ====
// counts failed restarts while the system rail stays under its threshold
`include "charger_status_regs.svh"
module uv_restart_monitor
  import charger_status_pkg::*;
#(
  parameter int RESTART_LIMIT = `RESTART_FAIL_LIMIT
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic below_uv,
  input  wire logic restart_failed,
  output logic      uv_fault
);

  localparam int CW = $clog2(RESTART_LIMIT + 1);

  typedef struct packed {
    uv_state_t     st;
    logic [CW-1:0] tries;
    logic          fault;
  } uv_mon_state_t;

  uv_mon_state_t state_d;
  uv_mon_state_t state_q;

  if (RESTART_LIMIT < 1) begin : g_bad_limit
    $error("uv_restart_monitor: RESTART_LIMIT must be at least 1");
  end

  always_comb begin
    state_d       = state_q;
    state_d.fault = 1'b0;
    case (state_q.st)
      UV_IDLE: begin
        state_d.tries = '0;
        if (below_uv && restart_failed) begin
          state_d.tries = CW'(1);
          state_d.st    = (RESTART_LIMIT == 1) ? UV_LATCHED : UV_RETRY;
          state_d.fault = (RESTART_LIMIT == 1);
        end
      end
      UV_RETRY: begin
        if (!below_uv) begin
          state_d.st = UV_IDLE;
        end else if (restart_failed) begin
          state_d.tries = state_q.tries + CW'(1);
          if (state_q.tries + CW'(1) == CW'(RESTART_LIMIT)) begin
            state_d.st    = UV_LATCHED;
            state_d.fault = 1'b1;
          end
        end
      end
      // one report per episode; a fresh dip starts a new count
      UV_LATCHED: begin
        if (!below_uv) state_d.st = UV_IDLE;
      end
      default: state_d.st = UV_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) state_q <= '{st: UV_IDLE, tries: '0, fault: 1'b0};
    else state_q <= state_d;
  end

  assign uv_fault = state_q.fault;

endmodule

// ==== logic/charger_status_fault_register.sv ====
// charger operating state and fault flag registers with host read and write
//
// Summary of operation
// RULE1 - bit4 shows voltage regulation, forward or OTG
// RULE2 - bit3 low unless input current regulation
// RULE3 - bit2 follows fast charge phase
// RULE4 - bit1 follows pre-charge phase
// RULE5 - bit0 follows reverse power mode
// RULE6 - fault bits 7,6,5,2,1,0 clear on read
// RULE7 - bit6 flags battery overcurrent normally
// RULE8 - pass-through: bit6 gated by overcurrent enable
// RULE9 - bit2 latches on forced converter shutdown
// RULE10 - bit1 latches on reverse output overvoltage
// RULE11 - bit0 latches on reverse output undervoltage
// RULE12 - bit4 latches system overvoltage, write clears
// RULE13 - converter held off while bit4 set
// RULE14 - write zero or unplug clears, converter resumes
// RULE15 - bit3 latches after seven failed restarts
// RULE16 - bit3 held until host write, resets zero
// RULE17 - event during clearing read keeps flag

`include "charger_status_regs.svh"

module charger_status_fault_register
  import charger_status_pkg::*;
#(
  parameter int RESTART_LIMIT = `RESTART_FAIL_LIMIT
) (
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire reg_req_t      reg_req,
  output logic      [7:0]    reg_rdata,
  input  wire live_status_t  live,
  input  wire fault_events_t events,
  input  wire mode_cfg_t     mode,
  output logic               converter_enable
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic addr_hit(input reg_req_t r, input logic [7:0] off);
    addr_hit = (r.addr == off);
  endfunction

  function automatic logic [7:0] fault_byte(input logic [5:0] rc, input logic ov,
                                            input logic uv);
    logic [7:0] b;
    b                         = `RST_FAULT_FLAGS;
    b[`BIT_INPUT_OV]          = rc[5];
    b[`BIT_BATTERY_OC]        = rc[4];
    b[`BIT_INPUT_OC]          = rc[3];
    b[`BIT_SYSTEM_OV]         = ov;
    b[`BIT_SYSTEM_UV]         = uv;
    b[`BIT_FORCED_SHUTDOWN]   = rc[2];
    b[`BIT_REVERSE_OUT_OV]    = rc[1];
    b[`BIT_REVERSE_OUT_UV]    = rc[0];
    fault_byte                = b;
  endfunction

  // checked at elaboration so a bad limit never reaches silicon
  if (RESTART_LIMIT < 1) begin : g_bad_limit
    $error("charger_status_fault_register: bad RESTART_LIMIT");
  end

  main_state_t state_d;
  main_state_t state_q;
  logic [5:0]  rc_set;
  logic [5:0]  rc_flags;
  logic        fault_read;
  logic        fault_write;
  logic        uv_fault;
  logic        batoc_source;
  logic        ov_write_clear;
  logic        uv_write_clear;
  logic        adapter_removed;

  // ****************************************
  // request decode
  // ****************************************
  assign fault_read  = reg_req.rd_en && addr_hit(reg_req, `OFF_FAULT_FLAGS);
  assign fault_write = reg_req.wr_en && addr_hit(reg_req, `OFF_FAULT_FLAGS);
  // writing one has no effect; only hardware may set these
  assign ov_write_clear = fault_write && !reg_req.wdata[`BIT_SYSTEM_OV];
  assign uv_write_clear = fault_write && !reg_req.wdata[`BIT_SYSTEM_UV];
  assign adapter_removed = state_q.adapter_prev && !mode.adapter_present;

  // ****************************************
  // read-clear fault sources
  // ****************************************
  always_comb begin
    if (!mode.pass_through_mode) begin
      batoc_source = events.battery_overcurrent;                                  // [RULE7]
    end else if (mode.battery_overcurrent_enable) begin
      batoc_source = events.battery_overcurrent || events.battery_overvoltage;    // [RULE8]
    end else begin
      batoc_source = 1'b0;                                                        // [RULE8]
    end
  end

  assign rc_set[5] = events.input_overvoltage;                                    // [RULE6]
  assign rc_set[4] = batoc_source;
  assign rc_set[3] = events.input_overcurrent;                                    // [RULE6]
  assign rc_set[2] = mode.forced_shutdown_command && !state_q.forced_prev;        // [RULE9]
  assign rc_set[1] = events.reverse_output_overvoltage;                           // [RULE10]
  assign rc_set[0] = events.reverse_output_undervoltage;                          // [RULE11]

  read_clear_flags #(
    .WIDTH (`READ_CLEAR_COUNT)
  ) u_flags (
    .clock      (clock),
    .rstn       (rstn),
    .set        (rc_set),
    .read_clear (fault_read),                                                     // [RULE6] [RULE17]
    .flags      (rc_flags)
  );

  uv_restart_monitor #(
    .RESTART_LIMIT (RESTART_LIMIT)
  ) u_uv_mon (
    .clock          (clock),
    .rstn           (rstn),
    .below_uv       (events.system_below_uv),
    .restart_failed (events.restart_failed),
    .uv_fault       (uv_fault)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_d              = state_q;
    state_d.adapter_prev = mode.adapter_present;
    state_d.forced_prev  = mode.forced_shutdown_command;

    state_d.op_state = `RST_OPERATING_STATE;
    state_d.op_state[`BIT_VOLTAGE_REG_ACTIVE] =
      (live.input_voltage_regulation && !live.reverse_power_active) ||
      (live.otg_voltage_regulation && live.reverse_power_active);                 // [RULE1]
    state_d.op_state[`BIT_CURRENT_REG_ACTIVE] =
      live.input_current_regulation && !live.reverse_power_active;                // [RULE2]
    state_d.op_state[`BIT_FAST_CHARGE]   = live.fast_charge_active;               // [RULE3]
    state_d.op_state[`BIT_PRECHARGE]     = live.precharge_active;                 // [RULE4]
    state_d.op_state[`BIT_REVERSE_POWER] = live.reverse_power_active;             // [RULE5]

    // a detector still active wins over the clear
    if (events.system_overvoltage) begin
      state_d.sys_ov = 1'b1;                                                      // [RULE12]
    end else if (ov_write_clear || adapter_removed) begin
      state_d.sys_ov = 1'b0;                                                      // [RULE14]
    end

    if (uv_fault) begin
      state_d.sys_uv = 1'b1;                                                      // [RULE15]
    end else if (uv_write_clear) begin
      state_d.sys_uv = 1'b0;                                                      // [RULE16]
    end

    // enable follows the latch so the converter restarts right after the clear
    state_d.conv_en = !state_d.sys_ov && !mode.forced_shutdown_command;          // [RULE13] [RULE14]

    if (reg_req.rd_en) begin
      if (addr_hit(reg_req, `OFF_OPERATING_STATE)) begin
        state_d.rdata = state_q.op_state;
      end else if (addr_hit(reg_req, `OFF_FAULT_FLAGS)) begin
        state_d.rdata = fault_byte(rc_flags, state_q.sys_ov, state_q.sys_uv);
      end else begin
        state_d.rdata = `RST_READ_DATA;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_q <= '{op_state: `RST_OPERATING_STATE, sys_ov: 1'b0, sys_uv: 1'b0,
                   rdata: `RST_READ_DATA, adapter_prev: 1'b0, forced_prev: 1'b0,
                   conv_en: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata        = state_q.rdata;
  assign converter_enable = state_q.conv_en;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence s_fault_read;
    fault_read;
  endsequence

  sequence s_quiet_sets;
    rc_set == 6'h00;
  endsequence

  sequence s_ov_clear_req;
    ov_write_clear && !events.system_overvoltage && !mode.forced_shutdown_command;
  endsequence

  a_voltage_reg_bit: assert property (                                            // [RULE1]
    live.reverse_power_active && live.otg_voltage_regulation
      |=> state_q.op_state[`BIT_VOLTAGE_REG_ACTIVE])
    else $error("voltage regulation bit missing in reverse mode");

  a_current_reg_low: assert property (                                            // [RULE2]
    (!live.input_current_regulation || live.reverse_power_active)
      |=> !state_q.op_state[`BIT_CURRENT_REG_ACTIVE])
    else $error("current regulation bit set outside forward regulation");

  a_phase_bits: assert property (                                                 // [RULE3]
    ##1 (state_q.op_state[`BIT_FAST_CHARGE] == $past(live.fast_charge_active)) &&
        (state_q.op_state[`BIT_PRECHARGE] == $past(live.precharge_active)))      // [RULE4]
    else $error("charge phase bits do not follow the phase");

  a_reverse_bit: assert property (                                                // [RULE5]
    $rose(live.reverse_power_active) |=> state_q.op_state[`BIT_REVERSE_POWER])
    else $error("reverse power bit did not rise");

  a_read_clears: assert property (                                                // [RULE6]
    s_fault_read and s_quiet_sets |=> rc_flags == 6'h00 ##1 reg_rdata == $past(reg_rdata))
    else $error("read did not clear the read-clear flags");

  a_read_keeps_set: assert property (                                             // [RULE17]
    s_fault_read and events.input_overvoltage |=> rc_flags[5] [*1] ##0 rc_flags[5])
    else $error("event during read was lost");

  a_read_returns: assert property (                                               // [RULE6]
    fault_read ##0 rc_flags[2] |=> reg_rdata[`BIT_FORCED_SHUTDOWN])
    else $error("read returned a flag as clear before clearing");

  a_batoc_normal: assert property (                                               // [RULE7]
    !mode.pass_through_mode && events.battery_overvoltage && !events.battery_overcurrent
      && !rc_flags[4] |=> !rc_flags[4])
    else $error("battery overvoltage flagged outside pass-through");

  a_ptm_frozen: assert property (                                                 // [RULE8]
    mode.pass_through_mode && !mode.battery_overcurrent_enable && !fault_read
      |=> $stable(rc_flags[4]))
    else $error("battery flag updated while disabled in pass-through");

  a_ptm_overvolt: assert property (                                               // [RULE8]
    mode.pass_through_mode && mode.battery_overcurrent_enable && events.battery_overvoltage
      |=> rc_flags[4])
    else $error("battery overvoltage not flagged in pass-through");

  a_forced_latch: assert property (                                               // [RULE9]
    $rose(mode.forced_shutdown_command) |=> rc_flags[2] ##0 !converter_enable)
    else $error("forced shutdown not latched");

  a_reverse_faults: assert property (                                             // [RULE10]
    events.reverse_output_overvoltage || events.reverse_output_undervoltage
      |=> rc_flags[1] || rc_flags[0])                                             // [RULE11]
    else $error("reverse output fault not latched");

  a_sys_ov_hold: assert property (                                                // [RULE12]
    state_q.sys_ov && !ov_write_clear && !adapter_removed |=> state_q.sys_ov)
    else $error("system overvoltage flag dropped without a clear");

  a_converter_off: assert property (                                              // [RULE13]
    state_q.sys_ov |-> !converter_enable)
    else $error("converter enabled during system overvoltage");

  a_ov_clear: assert property (                                                   // [RULE14]
    s_ov_clear_req |=> !state_q.sys_ov && converter_enable)
    else $error("overvoltage clear did not restart the converter");

  a_uv_latch: assert property (                                                   // [RULE15]
    uv_fault |=> state_q.sys_uv [*2])
    else $error("undervoltage fault not latched");

  a_uv_hold: assert property (                                                    // [RULE16]
    state_q.sys_uv && !uv_write_clear |=> state_q.sys_uv)
    else $error("undervoltage flag dropped without a write");

  // ****************************************
  // flag entry, hold and clear, read data and converter enable checks
  // ****************************************
  sequence s_op_read;
    reg_req.rd_en && addr_hit(reg_req, `OFF_OPERATING_STATE);
  endsequence

  sequence s_uv_clear_req;
    uv_write_clear && !uv_fault;
  endsequence

  a_ov_sets_latch: assert property (  // [RULE12]
    events.system_overvoltage |=> state_q.sys_ov)
    else $error("system overvoltage not latched");

  a_ov_entry: assert property (  // [RULE12]
    $rose(state_q.sys_ov) |-> $past(events.system_overvoltage))
    else $error("overvoltage flag rose without a trip");

  a_unplug_clears: assert property (  // [RULE14]
    adapter_removed && !events.system_overvoltage |=> !state_q.sys_ov)
    else $error("adapter removal did not clear the overvoltage latch");

  a_converter_on: assert property (  // [RULE14]
    !state_d.sys_ov && !mode.forced_shutdown_command |=> converter_enable)
    else $error("converter not enabled with no fault present");

  a_forced_conv_off: assert property (  // [RULE9]
    mode.forced_shutdown_command |=> !converter_enable)
    else $error("converter enabled during forced shutdown");

  a_uv_write_clear: assert property (  // [RULE16]
    s_uv_clear_req |=> !state_q.sys_uv)
    else $error("undervoltage write did not clear the flag");

  a_uv_entry: assert property (  // [RULE15]
    $rose(state_q.sys_uv) |-> $past(uv_fault))
    else $error("undervoltage flag rose without a failed restart run");

  a_rc_no_drop: assert property (  // [RULE6]
    !fault_read |=> (rc_flags & $past(rc_flags)) == $past(rc_flags))
    else $error("read-clear flag dropped without a read");

  a_rc_sets: assert property (  // [RULE17]
    rc_set != 6'h00 |=> (rc_flags & $past(rc_set)) == $past(rc_set))
    else $error("fault event did not latch its flag");

  a_op_read: assert property (  // [RULE1]
    s_op_read |=> reg_rdata == $past(state_q.op_state))
    else $error("operating state read returned stale data");

  a_rdata_stands: assert property (  // [RULE6]
    !reg_req.rd_en |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  a_batoc_sets: assert property (  // [RULE7]
    !mode.pass_through_mode && events.battery_overcurrent |=> rc_flags[4])
    else $error("battery overcurrent not flagged");

  a_ptm_overcurrent: assert property (  // [RULE8]
    mode.pass_through_mode && mode.battery_overcurrent_enable
      && events.battery_overcurrent |=> rc_flags[4])
    else $error("battery overcurrent not flagged in pass-through");

  a_rev_ov_latch: assert property (  // [RULE10]
    events.reverse_output_overvoltage |=> rc_flags[1])
    else $error("reverse output overvoltage not latched");

  a_rev_uv_latch: assert property (  // [RULE11]
    events.reverse_output_undervoltage |=> rc_flags[0])
    else $error("reverse output undervoltage not latched");

endmodule

// ==== verif/host_reg_model.sv ====
// host side model: issues register reads and writes one request at a time
module host_reg_model
  import charger_status_pkg::*;
(
  input  wire logic       clock,
  output reg_req_t        reg_req,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // request driver
  // ****************************************
  initial begin
    reg_req = '0;
  end

  // request launched after an edge, taken at the next one, data sampled once settled
  // no ready exists, so the hold is exactly one edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                        output logic [7:0] rd);
    @(posedge clock);
    reg_req <= '{rd_en: !wr, wr_en: wr, addr: a, wdata: wd};
    @(posedge clock);
    reg_req <= '0;
    #1 rd = reg_rdata;
  endtask
endmodule

// ==== verif/tb_charger_status_fault_register.sv ====
// self-checking bench for the charger status and fault flag registers
`include "charger_status_regs.svh"
module tb_charger_status_fault_register
  import charger_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // signals and instances
  // ****************************************
  logic          clock;
  logic          rstn;
  reg_req_t      reg_req;
  logic [7:0]    reg_rdata;
  live_status_t  live;
  fault_events_t events;
  mode_cfg_t     mode;
  logic          converter_enable;
  logic [7:0]    rd;
  int            fails;
  int            compares;

  typedef struct packed {
    logic [5:0] lv;
    logic [8:0] ev;
    logic [3:0] md;
    logic [7:0] addr;
    logic [7:0] exp;
  } row_t;

  // full restart count, so the undervoltage case walks every failed attempt
  charger_status_fault_register #(
    .RESTART_LIMIT (`RESTART_FAIL_LIMIT)
  ) u_charger_status_fault_register (
    .clock            (clock),
    .rstn             (rstn),
    .reg_req          (reg_req),
    .reg_rdata        (reg_rdata),
    .live             (live),
    .events           (events),
    .mode             (mode),
    .converter_enable (converter_enable)
  );

  host_reg_model u_host_reg_model (
    .clock     (clock),
    .reg_req   (reg_req),
    .reg_rdata (reg_rdata)
  );

  // ****************************************
  // clock, checks and verdict
  // ****************************************
  always #50 clock = ~clock;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    u_host_reg_model.access(1'b0, a, 8'h00, rd);
    chk(rd, exp);
  endtask

  task automatic conv_chk(input logic exp);
    @(posedge clock);
    #1 chk({7'h00, converter_enable}, {7'h00, exp});
  endtask

  // ****************************************
  // table: live levels, events, modes, address, expected byte
  // ****************************************
  row_t rows [20] = '{
    '{6'b100000, 9'h000, 4'h1, 8'h21, 8'h10},
    '{6'b010000, 9'h000, 4'h1, 8'h21, 8'h00},
    '{6'b010001, 9'h000, 4'h1, 8'h21, 8'h11},
    '{6'b100001, 9'h000, 4'h1, 8'h21, 8'h01},
    '{6'b001000, 9'h000, 4'h1, 8'h21, 8'h08},
    '{6'b001001, 9'h000, 4'h1, 8'h21, 8'h01},
    '{6'b000100, 9'h000, 4'h1, 8'h21, 8'h04},
    '{6'b000010, 9'h000, 4'h1, 8'h21, 8'h02},
    '{6'b111111, 9'h000, 4'h1, 8'h22, 8'h00},
    '{6'b000000, 9'h100, 4'h1, 8'h20, 8'h80},
    '{6'b000000, 9'h080, 4'h1, 8'h20, 8'h40},
    '{6'b000000, 9'h040, 4'h1, 8'h20, 8'h00},
    '{6'b000000, 9'h040, 4'hd, 8'h20, 8'h40},
    '{6'b000000, 9'h080, 4'hd, 8'h20, 8'h40},
    '{6'b000000, 9'h080, 4'h9, 8'h20, 8'h00},
    '{6'b000000, 9'h020, 4'h1, 8'h20, 8'h20},
    '{6'b000000, 9'h002, 4'h1, 8'h20, 8'h02},
    '{6'b000000, 9'h001, 4'h1, 8'h20, 8'h01},
    '{6'b000000, 9'h010, 4'h1, 8'h20, 8'h10},
    '{6'b000000, 9'h000, 4'h3, 8'h20, 8'h04}
  };

  initial begin
    clock    = 1'b0;
    rstn     = 1'b0;
    live     = '0;
    events   = '0;
    mode     = 4'h1;
    fails    = 0;
    compares = 0;
  end

  initial begin
    #(3000 * 100);
    fails++;
    final_report;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clock);
    #1 chk({7'h00, converter_enable}, 8'h00);
    @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    conv_chk(1'b1);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h21, 8'h00);
    foreach (rows[i]) begin
      @(posedge clock);
      live   <= rows[i].lv;
      events <= rows[i].ev;
      mode   <= rows[i].md;
      @(posedge clock);
      events <= '0;
      mode   <= 4'h1;
      repeat (2) @(posedge clock);
      rd_chk(rows[i].addr, rows[i].exp);
      if (rows[i].addr == 8'h20) begin
        rd_chk(8'h20, rows[i].exp & 8'h18);
        u_host_reg_model.access(1'b1, 8'h20, 8'h00, rd);
      end
    end
    // clear attempt while the overvoltage persists must not win
    @(posedge clock);
    events.system_overvoltage <= 1'b1;
    u_host_reg_model.access(1'b1, 8'h20, 8'h00, rd);
    events <= '0;
    repeat (2) conv_chk(1'b0);
    u_host_reg_model.access(1'b1, 8'h20, 8'h10, rd);
    conv_chk(1'b0);
    u_host_reg_model.access(1'b1, 8'h20, 8'h00, rd);
    conv_chk(1'b1);
    // adapter removal is the other way out of the latch
    @(posedge clock);
    events.system_overvoltage <= 1'b1;
    @(posedge clock);
    events <= '0;
    conv_chk(1'b0);
    mode.adapter_present <= 1'b0;
    repeat (2) conv_chk(1'b1);
    rd_chk(8'h20, 8'h00);
    mode.adapter_present <= 1'b1;
    // undervoltage: restarts fail while the rail stays low
    @(posedge clock);
    events.system_below_uv <= 1'b1;
    for (int k = 0; k < `RESTART_FAIL_LIMIT; k++) begin
      @(posedge clock);
      events.restart_failed <= 1'b1;
      @(posedge clock);
      events.restart_failed <= 1'b0;
      repeat (3) @(posedge clock);
      rd_chk(8'h20, (k == `RESTART_FAIL_LIMIT - 1) ? 8'h08 : 8'h00);
    end
    rd_chk(8'h20, 8'h08);
    events.system_below_uv <= 1'b0;
    u_host_reg_model.access(1'b1, 8'h20, 8'h00, rd);
    rd_chk(8'h20, 8'h00);
    // event landing on the clearing read must survive it
    @(posedge clock);
    events.input_overvoltage <= 1'b1;
    @(posedge clock);
    events <= '0;
    repeat (2) @(posedge clock);
    fork
      rd_chk(8'h20, 8'h80);
      begin
        @(posedge clock);
        events.input_overvoltage <= 1'b1;
        @(posedge clock);
        events <= '0;
      end
    join
    rd_chk(8'h20, 8'h80);
    rd_chk(8'h20, 8'h00);
    final_report;
  end
endmodule
